// File: rtl/dtx_map.svh
// Purpose: offsets, field positions and timing counts
// Assumes: apb byte addresses, 32-bit words, pclk at 100 MHz
// Notes:   included by the tone transceiver core and its package users
`ifndef DTX_MAP_SVH
`define DTX_MAP_SVH
// ==========================================================
// register offsets
`define DTX_OFF_TXDATA    12'h000
`define DTX_OFF_RXDATA    12'h004
`define DTX_OFF_CTRL_A    12'h008
`define DTX_OFF_CTRL_B    12'h00c
`define DTX_OFF_STATUS    12'h010
`define DTX_OFF_DIVCFG    12'h014
// ==========================================================
// control a fields
`define DTX_CA_TONE_EN    0
`define DTX_CA_PROGRESS   1
`define DTX_CA_IRQ_EN     2
// control b fields
`define DTX_CB_BURST      0
`define DTX_CB_RX_EN      1
`define DTX_CB_SINGLE     2
`define DTX_CB_COLUMN     3
// status fields
`define DTX_ST_IRQ        0
`define DTX_ST_TX_READY   1
`define DTX_ST_RX_FULL    2
`define DTX_ST_STEER      3
// ==========================================================
// timing
`define DTX_CLK_HZ        100000000
`define DTX_BURST_US      51000
`define DTX_BURST_CYC     ((`DTX_BURST_US / 1000) * (`DTX_CLK_HZ / 1000))
`define DTX_PRESENT_US    40000
`define DTX_ABSENT_US     40000
`define DTX_PRESENT_CYC   ((`DTX_PRESENT_US / 1000) * (`DTX_CLK_HZ / 1000))
`define DTX_ABSENT_CYC    ((`DTX_ABSENT_US / 1000) * (`DTX_CLK_HZ / 1000))
`define DTX_SEGMENTS      32
`define DTX_XTAL_DIV      28
`endif

// File: rtl/dtx_pkg.sv
// Purpose: shared types of the tone transceiver
// Assumes: nothing beyond the map header
// Notes:   constants live in dtx_map.svh
`default_nettype none
package dtx_pkg;
   typedef enum logic [1:0] {
      DTX_BURST_IDLE,
      DTX_BURST_TONE,
      DTX_BURST_PAUSE
   } dtx_burst_t;
   typedef enum logic [1:0] {
      DTX_RX_IDLE,
      DTX_RX_QUAL,
      DTX_RX_HELD,
      DTX_RX_DROP
   } dtx_rx_t;
endpackage
`default_nettype wire

// File: rtl/dtx_core.sv
// Purpose: tone transceiver digital core behind an apb slave
// Assumes: tone detector supplies pair-present level and decoded code
// Notes:   guard times counted in pclk cycles instead of an rc network
`default_nettype none
`include "dtx_map.svh"
module dtx_core #(
   parameter int unsigned BURST_CYC   = `DTX_BURST_CYC,
   parameter int unsigned PRESENT_CYC = `DTX_PRESENT_CYC,
   parameter int unsigned ABSENT_CYC  = `DTX_ABSENT_CYC,
   parameter int unsigned XTAL_DIV    = `DTX_XTAL_DIV
) (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        pair_present,
   input  wire logic [3:0]  pair_code,
   input  wire logic        progress_wave,
   output logic             early_steer_out,
   output logic             steer_in_guard_out,
   output logic [3:0]       rx_code_bits,
   output logic             irq_or_progress_wave_pin_o,
   output logic             irq_or_progress_wave_pin_oe,
   output logic [4:0]       low_phase,
   output logic [4:0]       high_phase,
   output logic             low_active,
   output logic             high_active,
   output logic             tone_out_oe
);
   // ==========================================================
   // apb slave
   logic        acc;
   logic        wr;
   logic        rd;
   logic [3:0]  tx_code_r;
   logic [2:0]  ctrl_a_r;
   logic [3:0]  ctrl_b_r;
   logic [3:0]  rx_r;
   logic        steer_r;
   logic        full_r;
   logic        rx_irq_r;
   logic        tx_ready_r;
   logic        tx_irq_r;
   logic        new_digit;
   logic        burst_done;
   logic        status_rd;
   logic        pin_low;

   assign acc       = psel & penable;
   assign wr        = acc & pwrite;
   assign rd        = acc & ~pwrite;
   assign status_rd = rd & (paddr == `DTX_OFF_STATUS);

   function automatic logic known(input logic [11:0] a);
      known = (a == `DTX_OFF_TXDATA) || (a == `DTX_OFF_RXDATA) ||
              (a == `DTX_OFF_CTRL_A) || (a == `DTX_OFF_CTRL_B) ||
              (a == `DTX_OFF_STATUS);
   endfunction

   logic tone_en;
   logic prog;
   logic irq_en;
   logic burst;
   logic rx_en;
   assign tone_en = ctrl_a_r[`DTX_CA_TONE_EN];
   assign prog    = ctrl_a_r[`DTX_CA_PROGRESS];
   assign irq_en  = ctrl_a_r[`DTX_CA_IRQ_EN];
   assign burst   = ctrl_b_r[`DTX_CB_BURST];
   assign rx_en   = ctrl_b_r[`DTX_CB_RX_EN] & ~prog;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h0;
      end else begin
         pready  <= psel & ~penable;
         pslverr <= psel & ~penable & ~known(paddr);
         prdata  <= 32'h0;
         if (psel & ~penable & ~pwrite) begin
            case (paddr)
               `DTX_OFF_RXDATA: prdata <= {28'h0, rx_r};
               `DTX_OFF_CTRL_A: prdata <= {29'h0, ctrl_a_r};
               `DTX_OFF_CTRL_B: prdata <= {28'h0, ctrl_b_r};
               `DTX_OFF_STATUS: prdata <= {28'h0, steer_r, full_r,
                                           tx_ready_r, rx_irq_r | tx_irq_r};
               default:         prdata <= 32'h0;
            endcase
         end
      end
   end

   // control registers; write effect on the ready access edge
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_a_r <= 3'h0;
         ctrl_b_r <= 4'h0;
      end else if (wr & pready) begin
         if (paddr == `DTX_OFF_CTRL_A)
            ctrl_a_r <= pwdata[2:0];
         if (paddr == `DTX_OFF_CTRL_B)
            ctrl_b_r <= pwdata[3:0];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tx_code_r <= 4'h0;
      end else if (!tone_en) begin
         tx_code_r <= 4'h0;
      end else if (wr & pready & (paddr == `DTX_OFF_TXDATA)) begin
         tx_code_r <= pwdata[3:0];
      end
   end

   // ==========================================================
   // receive steering: counters stand in for the rc guard network
   dtx_pkg::dtx_rx_t rx_st;
   logic [31:0]      guard_cnt;
   logic             sig;
   assign sig = pair_present & rx_en;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rx_st     <= dtx_pkg::DTX_RX_IDLE;
         guard_cnt <= 32'h0;
         new_digit <= 1'b0;
      end else begin
         new_digit <= 1'b0;
         case (rx_st)
            dtx_pkg::DTX_RX_IDLE: begin
               guard_cnt <= 32'h0;
               if (sig)
                  rx_st <= dtx_pkg::DTX_RX_QUAL;
            end
            dtx_pkg::DTX_RX_QUAL: begin
               if (!sig) begin
                  rx_st <= dtx_pkg::DTX_RX_IDLE;
               end else if (guard_cnt >= PRESENT_CYC - 1) begin
                  rx_st     <= dtx_pkg::DTX_RX_HELD;
                  new_digit <= 1'b1;
                  guard_cnt <= 32'h0;
               end else begin
                  guard_cnt <= guard_cnt + 32'h1;
               end
            end
            dtx_pkg::DTX_RX_HELD: begin
               guard_cnt <= 32'h0;
               if (!sig)
                  rx_st <= dtx_pkg::DTX_RX_DROP;
            end
            dtx_pkg::DTX_RX_DROP: begin
               if (sig) begin
                  rx_st     <= dtx_pkg::DTX_RX_HELD;
                  guard_cnt <= 32'h0;
               end else if (guard_cnt >= ABSENT_CYC - 1) begin
                  rx_st <= dtx_pkg::DTX_RX_IDLE;
               end else begin
                  guard_cnt <= guard_cnt + 32'h1;
               end
            end
            default: rx_st <= dtx_pkg::DTX_RX_IDLE;
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rx_r               <= 4'h0;
         rx_code_bits       <= 4'h0;
         steer_r            <= 1'b0;
         early_steer_out    <= 1'b0;
         steer_in_guard_out <= 1'b0;
      end else begin
         early_steer_out    <= sig;
         steer_in_guard_out <= rx_st == dtx_pkg::DTX_RX_HELD;
         steer_r <= (rx_st == dtx_pkg::DTX_RX_HELD) ||
                    (rx_st == dtx_pkg::DTX_RX_DROP);
         if (rx_st == dtx_pkg::DTX_RX_QUAL && sig &&
             guard_cnt >= PRESENT_CYC - 1) begin
            rx_r         <= pair_code;
            rx_code_bits <= pair_code;
         end
      end
   end

   // set beats the clearing status read
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         full_r   <= 1'b0;
         rx_irq_r <= 1'b0;
         tx_irq_r <= 1'b0;
      end else begin
         if (new_digit) begin
            full_r   <= 1'b1;
            rx_irq_r <= 1'b1;
         end else if (status_rd & pready) begin
            full_r   <= 1'b0;
            rx_irq_r <= 1'b0;
         end
         if (burst_done)
            tx_irq_r <= 1'b1;
         else if (status_rd & pready)
            tx_irq_r <= 1'b0;
      end
   end

   // ==========================================================
   // tone synthesis: divider per group steps a 32-entry phase
   logic [7:0] lo_term;
   logic [7:0] hi_term;
   logic [1:0] row;
   logic [1:0] col;

   // code to row/column pair, same table as the receiver
   always_comb begin
      case (tx_code_r)
         4'h1: begin row = 2'h0; col = 2'h0; end
         4'h2: begin row = 2'h0; col = 2'h1; end
         4'h3: begin row = 2'h0; col = 2'h2; end
         4'h4: begin row = 2'h1; col = 2'h0; end
         4'h5: begin row = 2'h1; col = 2'h1; end
         4'h6: begin row = 2'h1; col = 2'h2; end
         4'h7: begin row = 2'h2; col = 2'h0; end
         4'h8: begin row = 2'h2; col = 2'h1; end
         4'h9: begin row = 2'h2; col = 2'h2; end
         4'ha: begin row = 2'h3; col = 2'h1; end
         4'hb: begin row = 2'h3; col = 2'h0; end
         4'hc: begin row = 2'h3; col = 2'h2; end
         4'hd: begin row = 2'h0; col = 2'h3; end
         4'he: begin row = 2'h1; col = 2'h3; end
         4'hf: begin row = 2'h2; col = 2'h3; end
         default: begin row = 2'h3; col = 2'h3; end
      endcase
   end

   // segment length in crystal ticks: 3.579545e6/(32*f)
   always_comb begin
      case (row)
         2'h0: lo_term = 8'ha0;
         2'h1: lo_term = 8'h92;
         2'h2: lo_term = 8'h84;
         default: lo_term = 8'h76;
      endcase
      case (col)
         2'h0: hi_term = 8'h5c;
         2'h1: hi_term = 8'h54;
         2'h2: hi_term = 8'h4c;
         default: hi_term = 8'h44;
      endcase
   end

   // crystal-rate tick from pclk; approximates 3.579545 MHz
   logic [7:0] xt_cnt;
   logic       xt_tick;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         xt_cnt  <= 8'h0;
         xt_tick <= 1'b0;
      end else begin
         xt_tick <= xt_cnt == XTAL_DIV[7:0] - 8'h1;
         xt_cnt  <= (xt_cnt == XTAL_DIV[7:0] - 8'h1) ? 8'h0 : xt_cnt + 8'h1;
      end
   end

   logic       sending;
   logic [4:0] ph_lo;
   logic [4:0] ph_hi;

   // one divider and phase counter per group, each with its own driver
   genvar g;
   generate
      for (g = 0; g < 2; g++) begin : grp
         logic [7:0] div_cnt_r;
         logic [7:0] term;
         logic [4:0] ph_r;
         assign term = (g == 0) ? lo_term : hi_term;
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               div_cnt_r <= 8'h0;
               ph_r      <= 5'h0;
            end else if (!sending) begin
               div_cnt_r <= 8'h0;
               ph_r      <= 5'h0;
            end else if (xt_tick) begin
               if (div_cnt_r >= term - 8'h1) begin
                  div_cnt_r <= 8'h0;
                  ph_r      <= ph_r + 5'h1;
               end else begin
                  div_cnt_r <= div_cnt_r + 8'h1;
               end
            end
         end
      end
   endgenerate
   assign ph_lo = grp[0].ph_r;
   assign ph_hi = grp[1].ph_r;

   // ==========================================================
   // burst timer
   dtx_pkg::dtx_burst_t bst;
   logic [31:0]         bcnt;
   logic [31:0]         blen;
   assign blen = prog ? (BURST_CYC * 2) : BURST_CYC;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         bst        <= dtx_pkg::DTX_BURST_IDLE;
         bcnt       <= 32'h0;
         burst_done <= 1'b0;
         tx_ready_r <= 1'b0;
      end else begin
         burst_done <= 1'b0;
         if (wr & pready & (paddr == `DTX_OFF_TXDATA))
            tx_ready_r <= 1'b0;
         case (bst)
            dtx_pkg::DTX_BURST_IDLE: begin
               bcnt <= 32'h0;
               if (burst & tone_en & wr & pready &
                   (paddr == `DTX_OFF_TXDATA))
                  bst <= dtx_pkg::DTX_BURST_TONE;
            end
            dtx_pkg::DTX_BURST_TONE: begin
               if (bcnt >= blen - 1) begin
                  bcnt <= 32'h0;
                  bst  <= dtx_pkg::DTX_BURST_PAUSE;
               end else begin
                  bcnt <= bcnt + 32'h1;
               end
            end
            dtx_pkg::DTX_BURST_PAUSE: begin
               if (bcnt >= blen - 1) begin
                  bst        <= dtx_pkg::DTX_BURST_IDLE;
                  burst_done <= 1'b1;
                  tx_ready_r <= 1'b1;
               end else begin
                  bcnt <= bcnt + 32'h1;
               end
            end
            default: bst <= dtx_pkg::DTX_BURST_IDLE;
         endcase
         if (!tone_en | !burst)
            bst <= dtx_pkg::DTX_BURST_IDLE;
      end
   end

   // host times non-burst tones by toggling tone enable
   assign sending = tone_en &
                    (burst ? (bst == dtx_pkg::DTX_BURST_TONE) : 1'b1);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         low_phase   <= 5'h0;
         high_phase  <= 5'h0;
         low_active  <= 1'b0;
         high_active <= 1'b0;
         tone_out_oe <= 1'b0;
      end else begin
         low_phase   <= ph_lo;
         high_phase  <= ph_hi;
         // single tone picks one group
         low_active  <= sending & ~(ctrl_b_r[`DTX_CB_SINGLE] &
                                    ctrl_b_r[`DTX_CB_COLUMN]);
         high_active <= sending & ~(ctrl_b_r[`DTX_CB_SINGLE] &
                                    ~ctrl_b_r[`DTX_CB_COLUMN]);
         tone_out_oe <= tone_en;
      end
   end

   // ==========================================================
   // shared open-drain pin: low when driven
   always_comb begin
      if (prog)
         pin_low = ~(irq_en & progress_wave);
      else
         pin_low = irq_en & (rx_irq_r | (tx_irq_r & burst));
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_or_progress_wave_pin_o  <= 1'b0;
         irq_or_progress_wave_pin_oe <= 1'b0;
      end else begin
         irq_or_progress_wave_pin_o  <= 1'b0;
         irq_or_progress_wave_pin_oe <= pin_low;
      end
   end

   // ==========================================================
   // checks
   AST_NO_RX_IN_PROG: assert property (@(posedge pclk) disable iff (!presetn)
      prog |=> !new_digit) else $error("digit in progress mode");
   AST_FULL_ON_NEW: assert property (@(posedge pclk) disable iff (!presetn)
      new_digit |=> full_r && rx_irq_r) else $error("full not set");
   AST_RD_CLEARS: assert property (@(posedge pclk) disable iff (!presetn)
      status_rd && pready && !new_digit |=> !full_r && !rx_irq_r)
      else $error("status read did not clear");
   AST_HOLD_CODE: assert property (@(posedge pclk) disable iff (!presetn)
      !new_digit |-> $stable(rx_r))
      else $error("rx code changed");
   AST_TXCLR: assert property (@(posedge pclk) disable iff (!presetn)
      !tone_en |=> tx_code_r == 4'h0 && !tone_out_oe)
      else $error("tx not cleared");
   AST_READY_SET: assert property (@(posedge pclk) disable iff (!presetn)
      burst_done |-> tx_ready_r) else $error("ready not set");
   AST_STEER: assert property (@(posedge pclk) disable iff (!presetn)
      new_digit |=> steer_r) else $error("steer not set");
   AST_PIN_PROG: assert property (@(posedge pclk) disable iff (!presetn)
      prog && !irq_en |=> irq_or_progress_wave_pin_oe)
      else $error("pin not low");
endmodule
`default_nettype wire

// File: testbench/dtx_tone_src.sv
// Purpose: tone detector front end feeding the transceiver core
// Assumes: bench commands tone presence, code and progress wave
// Notes:   code lines toggle while no pair is present
`default_nettype none
module dtx_tone_src (
   input  wire logic       pclk,
   input  wire logic       presetn,
   input  wire logic       tone_on,
   input  wire logic [3:0] tone_code,
   input  wire logic       wave_on,
   output logic            pair_present,
   output logic [3:0]      pair_code,
   output logic            progress_wave
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [1:0] div_r;
   // ==========================================================
   // detector outputs
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pair_present <= 1'b0;
         pair_code    <= 4'h0;
      end else begin
         pair_present <= tone_on;
         // released code lines alternate between the last digit and its complement
         pair_code    <= tone_on ? tone_code : ~pair_code;
      end
   end
   // ==========================================================
   // limited progress tone, square wave of four-cycle halves
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         div_r         <= 2'h0;
         progress_wave <= 1'b0;
      end else begin
         div_r         <= div_r + 2'h1;
         if (!wave_on) begin
            progress_wave <= 1'b0;
         end else if (div_r == 2'h3) begin
            progress_wave <= ~progress_wave;
         end
      end
   end
endmodule
`default_nettype wire

// File: testbench/dtmf_tone_burst_and_rx_status_tb_top.sv
// Purpose: self-checking bench of the tone transceiver core
// Assumes: short guard and burst counts set by parameters
// Notes:   expectations kept in m_code and constants; only the table step reads its start phase from low_phase
`default_nettype none
`include "dtx_map.svh"
module dtmf_tone_burst_and_rx_status_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int BC = 50;
   localparam int GC = 20;
   logic        pclk = 1'b0;
   logic        presetn = 1'b0;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic        tone_on = 1'b0;
   logic [3:0]  tone_code = 4'h0;
   logic        wave_on = 1'b0;
   logic [31:0] prdata;
   logic        pready, pslverr, pair_present, progress_wave;
   logic        early_steer_out, steer_in_guard_out, low_active;
   logic        high_active, tone_out_oe, pin_o, pin_oe;
   logic [3:0]  rx_code_bits, pair_code;
   logic [4:0]  low_phase, high_phase;
   int          n_fail = 0;
   int          n_checks = 0;
   int          cyc = 0;
   int          seed;
   // ==========================================================
   // clock, timeout, instances
   always #5 pclk = ~pclk;
   always @(posedge pclk) begin
      cyc++;
      if (cyc == 60000) begin
         n_fail++;
         end_of_test();
      end
   end
   dtx_tone_src i_src (.pclk(pclk), .presetn(presetn), .tone_on(tone_on),
      .tone_code(tone_code), .wave_on(wave_on), .pair_present(pair_present),
      .pair_code(pair_code), .progress_wave(progress_wave));
   dtx_core #(.BURST_CYC(BC), .PRESENT_CYC(GC), .ABSENT_CYC(GC)) i_dut (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .pair_present(pair_present),
      .pair_code(pair_code), .progress_wave(progress_wave),
      .early_steer_out(early_steer_out),
      .steer_in_guard_out(steer_in_guard_out), .rx_code_bits(rx_code_bits),
      .irq_or_progress_wave_pin_o(pin_o),
      .irq_or_progress_wave_pin_oe(pin_oe), .low_phase(low_phase),
      .high_phase(high_phase), .low_active(low_active),
      .high_active(high_active), .tone_out_oe(tone_out_oe));
   // ==========================================================
   // tasks
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                      input string m);
      n_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("mismatch at %0t: %s got %h exp %h", $time, m, got, exp);
      end
   endtask
   // setup on the next edge, hold until pready is sampled high
   task automatic apb(input logic w, input logic [11:0] a,
                      input logic [31:0] d, output logic [31:0] q,
                      output logic e);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      chk(32'(n < 20), 32'h1, "apb answer");
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      logic [31:0] q;
      logic        e;
      apb(1'b1, a, d, q, e);
   endtask
   task automatic rd(input logic [11:0] a, output logic [31:0] q);
      logic e;
      apb(1'b0, a, 32'h0, q, e);
   endtask
   task automatic hold(input logic on, input int n);
      tone_on <= on;
      repeat (n) @(posedge pclk);
   endtask
   task automatic watch(output int h);
      h = 0;
      repeat (40) begin
         @(posedge pclk);
         if (pin_oe === 1'b1) h++;
      end
   endtask
   task automatic burst(input logic [3:0] c, input int exp);
      int          n;
      int          h;
      logic [31:0] q;
      n = 0;
      h = 0;
      wr(`DTX_OFF_TXDATA, {28'h0, c});
      while (low_active !== 1'b1 && n < 20) begin
         @(posedge pclk);
         n++;
      end
      while (low_active === 1'b1 && h < 400) begin
         @(posedge pclk);
         h++;
      end
      chk(32'(h >= exp - 3 && h <= exp + 3), 32'h1, "burst len");
      repeat (exp + 5) @(posedge pclk);
      chk(32'(pin_oe), 32'h1, "tx ready pin");
      rd(`DTX_OFF_STATUS, q);
      chk(32'(q[`DTX_ST_TX_READY]), 32'h1, "tx ready bit");
   endtask
   // ==========================================================
   // main sequence
   initial begin
      logic [31:0] q;
      logic        e;
      logic [3:0]  c;
      logic [3:0]  m_code;
      logic [4:0]  p;
      int          h;
      seed = 67;
      m_code = 4'h0;
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      rd(`DTX_OFF_STATUS, q);
      chk(q, 32'h0, "status after reset");
      apb(1'b0, 12'h0f0, 32'h0, q, e);
      chk({q[30:0], e}, 32'h1, "unmapped");
      wr(`DTX_OFF_CTRL_A, 32'h5);
      wr(`DTX_OFF_CTRL_B, 32'h2);
      tone_code <= 4'h3;
      hold(1'b1, GC / 2);
      hold(1'b0, 2 * GC);
      rd(`DTX_OFF_RXDATA, q);
      chk(q, 32'(m_code), "short tone");
      for (int i = 0; i < 4; i++) begin
         c = 4'($random(seed));
         m_code = c;
         tone_code <= c;
         hold(1'b1, 2 * GC);
         chk(32'(pin_oe), 32'h1, "rx irq");
         rd(`DTX_OFF_STATUS, q);
         chk(32'(q[3:2]), 32'h3, "steer and full");
         chk(32'({early_steer_out, rx_code_bits}), 32'({1'b1, m_code}),
             "rx code");
         rd(`DTX_OFF_STATUS, q);
         chk(32'({q[2], q[0], pin_oe, pin_o}), 32'h0, "read clears");
         hold(1'b0, GC / 4);
         hold(1'b1, GC / 2);
         chk(32'({steer_in_guard_out, rx_code_bits}), 32'({1'b1, m_code}),
             "dropout");
         hold(1'b0, 2 * GC);
         rd(`DTX_OFF_STATUS, q);
         chk(32'({q[3], q[2], early_steer_out}), 32'h0, "steer off");
         chk(32'(rx_code_bits), 32'(m_code), "code kept");
      end
      wr(`DTX_OFF_CTRL_A, 32'h7);
      tone_code <= ~m_code;
      hold(1'b1, 2 * GC);
      hold(1'b0, GC);
      chk(32'(rx_code_bits), 32'(m_code), "progress digit");
      watch(h);
      chk(32'(h), 32'd40, "no tone low");
      wave_on <= 1'b1;
      watch(h);
      chk(32'(h > 0 && h < 40), 32'h1, "wave on pin");
      wr(`DTX_OFF_CTRL_A, 32'h3);
      watch(h);
      chk(32'(h), 32'd40, "wave masked");
      wave_on <= 1'b0;
      wr(`DTX_OFF_CTRL_A, 32'h5);
      wr(`DTX_OFF_CTRL_B, 32'h3);
      burst(4'h1, BC);
      wr(`DTX_OFF_CTRL_A, 32'h7);
      tone_code <= ~m_code;
      tone_on <= 1'b1;
      burst(4'hd, 2 * BC);
      tone_on <= 1'b0;
      chk(32'(rx_code_bits), 32'(m_code), "burst no rx");
      wr(`DTX_OFF_CTRL_A, 32'h1);
      wr(`DTX_OFF_CTRL_B, 32'h4);
      wr(`DTX_OFF_TXDATA, 32'h1);
      repeat (3) @(posedge pclk);
      chk(32'({low_active, high_active}), 32'h2, "single low");
      wr(`DTX_OFF_CTRL_B, 32'hc);
      wr(`DTX_OFF_TXDATA, 32'h1);
      repeat (3) @(posedge pclk);
      chk(32'({low_active, high_active}), 32'h1, "single high");
      wr(`DTX_OFF_CTRL_B, 32'h0);
      wr(`DTX_OFF_TXDATA, 32'h1);
      p = low_phase;
      h = 0;
      while (low_phase === p && h < 10000) begin
         @(posedge pclk);
         h++;
      end
      p = p + 5'h1;
      chk(32'(low_phase), 32'(p), "table step");
      // transmitter toggled by host for its own timing
      wr(`DTX_OFF_CTRL_A, 32'h0);
      repeat (3) @(posedge pclk);
      chk(32'({tone_out_oe, low_active, high_active, low_phase, high_phase}),
          32'h0, "tx off");
      end_of_test();
   end
endmodule
`default_nettype wire
